/* hdl/pacd_pkg.sv */
/*
  Shared constants and types for the PHY auto-negotiation and cable
  diagnostic register bank: offsets, bit positions, reset values, carriers.
  Assumes a 16-bit register port clocked by sys_clk.
*/
package pacd_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int COUNT_W = 9;

  // Register offsets, as printed
  localparam logic [ADDR_W-1:0] OFF_DIAG = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SPECIAL = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_ADVERT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_PARTNER = 4'ha;

  // Ability field positions, shared by advertisement and partner registers
  localparam int BIT_PAUSE = 10;
  localparam int BIT_RSVD9 = 9;
  localparam int BIT_100FD = 8;
  localparam int BIT_100HD = 7;
  localparam int BIT_10FD = 6;
  localparam int BIT_10HD = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam logic [SEL_W-1:0] SELECTOR_8023 = 5'h01;

  // Diagnostic register fields
  localparam int BIT_DIAG_EN = 15;
  localparam int RESULT_LSB = 13;
  localparam int RESULT_W = 2;
  localparam int BIT_NEAR_SHORT = 12;
  localparam int COUNT_LSB = 0;

  // Special control/status fields
  localparam int BIT_POLARITY = 5;
  localparam int BIT_CROSSOVER = 4;
  localparam int BIT_FORCE_LINK = 3;
  localparam int BIT_PWRSAVE_OFF = 2;
  localparam int BIT_REMOTE_LB = 1;
  localparam int BIT_SPECIAL_RSVD0 = 0;

  // Reset values of writable bits and of read-only status fields
  localparam logic RST_PAUSE = 1'h1;
  localparam logic RST_ADV_SPEED = 1'h1;
  localparam logic RST_RSVD = 1'h0;
  localparam logic RST_FORCE_LINK = 1'h0;
  localparam logic RST_PWRSAVE_OFF = 1'h1;
  localparam logic RST_REMOTE_LB = 1'h0;
  localparam logic RST_STATUS = 1'h0;
  localparam logic [1:0] RST_RESULT = 2'h0;
  localparam logic [COUNT_W-1:0] RST_COUNT = 9'h000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    RESULT_NORMAL = 2'h0,
    RESULT_OPEN = 2'h1,
    RESULT_SHORT = 2'h2,
    RESULT_FAILED = 2'h3
  } pacd_result_type;

  typedef struct packed {
    logic pause;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } pacd_ability_type;

  typedef struct packed {
    pacd_result_type result;
    logic nearShort;
    logic [COUNT_W-1:0] faultCount;
  } pacd_diag_type;

  typedef struct packed {
    logic forceLink;
    logic powerSaveOff;
    logic remoteLoopback;
  } pacd_special_type;

endpackage

/* hdl/pacd_regs.sv */
/*
  Register bank for one port's auto-negotiation advertisement and partner
  ability, and the same port's cable diagnostic and special control/status.
  Assumes the PHY core runs on sys_clk, pulses diagDone once per started test
  with the outcome valid beside it, and holds partner/status levels steady.
*/
// The address-and-strobe port is this design's own decision.
module pacd_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [pacd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pacd_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [pacd_pkg::DATA_W-1:0] regRdData,
  // Auto-negotiation side of the PHY
  output pacd_pkg::pacd_ability_type advertise,
  input wire pacd_pkg::pacd_ability_type partnerAbility,
  // Cable diagnostic engine
  output logic diagStart,
  output logic diagRunning,
  input wire logic diagDone,
  input wire pacd_pkg::pacd_diag_type diagOutcome,
  // PHY status and control
  input wire logic polarityReversed,
  input wire logic crossoverState,
  output pacd_pkg::pacd_special_type specialCtrl
);
  import pacd_pkg::*;

  typedef enum logic [1:0] {
    DIAG_IDLE,
    DIAG_RUN,
    DIAG_LATCHED
  } pacd_diag_state_type;

  // Decode of a write to one register
  function automatic logic wrHit(input logic stb, input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] off);
    wrHit = stb && (addr == off);
  endfunction

  // Places the ability bits in their positions of a 16-bit word
  function automatic logic [DATA_W-1:0] abilityWord(input pacd_ability_type a,
                                                    input logic rsvd9);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    w[BIT_PAUSE] = a.pause;
    w[BIT_RSVD9] = rsvd9;
    w[BIT_100FD] = a.fd100;
    w[BIT_100HD] = a.hd100;
    w[BIT_10FD] = a.fd10;
    w[BIT_10HD] = a.hd10;
    w[SEL_LSB +: SEL_W] = SELECTOR_8023;
    abilityWord = w;
  endfunction

  pacd_ability_type advert_ff;
  logic advRsvd9_ff;
  pacd_ability_type partner_ff;
  pacd_special_type special_ff;
  logic specialRsvd0_ff;
  logic polarity_ff;
  logic crossover_ff;
  pacd_diag_type diagResult_ff;
  pacd_diag_state_type diagState_ff;
  pacd_diag_state_type nxt_diagState;
  logic diagStart_ff;
  logic [DATA_W-1:0] regRdData_ff;
  logic [DATA_W-1:0] nxt_regRdData;
  logic wrAdvert;
  logic wrSpecial;
  logic wrDiag;
  logic startReq;

  assign wrAdvert = wrHit(regWrStb, regAddr, OFF_ADVERT);
  assign wrSpecial = wrHit(regWrStb, regAddr, OFF_SPECIAL);
  assign wrDiag = wrHit(regWrStb, regAddr, OFF_DIAG);
  assign startReq = wrDiag && regWrData[BIT_DIAG_EN];

  // Advertisement: only the ability bits and reserved bit 9 are stored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      advert_ff.pause <= RST_PAUSE;
      advert_ff.fd100 <= RST_ADV_SPEED;
      advert_ff.hd100 <= RST_ADV_SPEED;
      advert_ff.fd10 <= RST_ADV_SPEED;
      advert_ff.hd10 <= RST_ADV_SPEED;
      advRsvd9_ff <= RST_RSVD;
    end else if (wrAdvert) begin
      advert_ff.pause <= regWrData[BIT_PAUSE];
      advert_ff.fd100 <= regWrData[BIT_100FD];
      advert_ff.hd100 <= regWrData[BIT_100HD];
      advert_ff.fd10 <= regWrData[BIT_10FD];
      advert_ff.hd10 <= regWrData[BIT_10HD];
      advRsvd9_ff <= regWrData[BIT_RSVD9];
    end
  end

  // One copy drives the PHY and every read path
  assign advertise = advert_ff;

  // Partner ability mirrors what the PHY learned; software cannot write it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      partner_ff <= '0;
    end else begin
      partner_ff <= partnerAbility;
    end
  end

  // Special control bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      special_ff.forceLink <= RST_FORCE_LINK;
      special_ff.powerSaveOff <= RST_PWRSAVE_OFF;
      special_ff.remoteLoopback <= RST_REMOTE_LB;
      specialRsvd0_ff <= RST_RSVD;
    end else if (wrSpecial) begin
      special_ff.forceLink <= regWrData[BIT_FORCE_LINK];
      special_ff.powerSaveOff <= regWrData[BIT_PWRSAVE_OFF];
      special_ff.remoteLoopback <= regWrData[BIT_REMOTE_LB];
      specialRsvd0_ff <= regWrData[BIT_SPECIAL_RSVD0];
    end
  end

  assign specialCtrl = special_ff;

  // PHY status levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polarity_ff <= RST_STATUS;
      crossover_ff <= RST_STATUS;
    end else begin
      polarity_ff <= polarityReversed;
      crossover_ff <= crossoverState;
    end
  end

  // Diagnostic sequencer: results are latched one cycle before enable drops
  always_comb begin
    nxt_diagState = diagState_ff;
    unique case (diagState_ff)
      DIAG_IDLE: begin
        if (startReq) begin
          nxt_diagState = DIAG_RUN;
        end
      end
      DIAG_RUN: begin
        if (diagDone) begin
          nxt_diagState = DIAG_LATCHED;
        end
      end
      DIAG_LATCHED: begin
        nxt_diagState = DIAG_IDLE;
      end
      default: begin
        nxt_diagState = DIAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diagState_ff <= DIAG_IDLE;
    end else begin
      diagState_ff <= nxt_diagState;
    end
  end

  // One-cycle start pulse toward the measurement engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diagStart_ff <= RST_STATUS;
    end else begin
      diagStart_ff <= (diagState_ff == DIAG_IDLE) && startReq;
    end
  end

  assign diagStart = diagStart_ff;
  assign diagRunning = (diagState_ff != DIAG_IDLE);

  // Outcome fields are captured only when the engine reports completion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diagResult_ff.result <= pacd_result_type'(RST_RESULT);
      diagResult_ff.nearShort <= RST_STATUS;
      diagResult_ff.faultCount <= RST_COUNT;
    end else if ((diagState_ff == DIAG_RUN) && diagDone) begin
      diagResult_ff.result <= diagOutcome.result;
      diagResult_ff.nearShort <= diagOutcome.nearShort;
      diagResult_ff.faultCount <= diagOutcome.faultCount;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_regRdData = ZERO_WORD;
    if (regRdStb) begin
      unique case (regAddr)
        OFF_ADVERT: begin
          nxt_regRdData = abilityWord(advert_ff, advRsvd9_ff);
        end
        OFF_PARTNER: begin
          nxt_regRdData = abilityWord(partner_ff, 1'h0);
        end
        OFF_DIAG: begin
          nxt_regRdData[BIT_DIAG_EN] = diagRunning;
          nxt_regRdData[RESULT_LSB +: RESULT_W] = diagResult_ff.result;
          nxt_regRdData[BIT_NEAR_SHORT] = diagResult_ff.nearShort;
          nxt_regRdData[COUNT_LSB +: COUNT_W] = diagResult_ff.faultCount;
        end
        OFF_SPECIAL: begin
          nxt_regRdData[BIT_POLARITY] = polarity_ff;
          nxt_regRdData[BIT_CROSSOVER] = crossover_ff;
          nxt_regRdData[BIT_FORCE_LINK] = special_ff.forceLink;
          nxt_regRdData[BIT_PWRSAVE_OFF] = special_ff.powerSaveOff;
          nxt_regRdData[BIT_REMOTE_LB] = special_ff.remoteLoopback;
          nxt_regRdData[BIT_SPECIAL_RSVD0] = specialRsvd0_ff;
        end
        default: begin
          nxt_regRdData = ZERO_WORD;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData_ff <= ZERO_WORD;
    end else begin
      regRdData_ff <= nxt_regRdData;
    end
  end

  assign regRdData = regRdData_ff;

endmodule // pacd_regs

/* testbench/pacd_regs_chk.sv */
/*
  Concurrent checks on the register port, control outputs and diagnostic handshake.
  Assumes it sees only the ports of pacd_regs; attached by the bind below.
*/
module pacd_regs_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [pacd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pacd_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [pacd_pkg::DATA_W-1:0] regRdData,
  // PHY side
  input wire pacd_pkg::pacd_ability_type advertise,
  input wire pacd_pkg::pacd_ability_type partnerAbility,
  input wire logic diagStart,
  input wire logic diagRunning,
  input wire logic diagDone,
  input wire pacd_pkg::pacd_diag_type diagOutcome,
  input wire logic polarityReversed,
  input wire logic crossoverState,
  input wire pacd_pkg::pacd_special_type specialCtrl
);
  timeunit 1ns;
  timeprecision 1ns;
  import pacd_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence start_seq;
    diagStart && diagRunning ##1 !diagStart;
  endsequence
  // Enable stays up for the latch cycle, then drops
  sequence clear_seq;
    diagRunning ##1 !diagRunning;
  endsequence
  adv_write_a: assert property (
    regWrStb && regAddr == OFF_ADVERT |=> advertise == {$past(regWrData[10]), $past(regWrData[8:5])})
    else $error("advertise differs from written word");
  spc_write_a: assert property (
    regWrStb && regAddr == OFF_SPECIAL |=> specialCtrl == $past(regWrData[3:1]))
    else $error("specialCtrl differs from written word");
  diag_start_a: assert property (
    regWrStb && regAddr == OFF_DIAG && regWrData[15] && !diagRunning |=> start_seq)
    else $error("diagnostic start not taken");
  start_cause_a: assert property (
    diagStart |-> $past(regWrStb) && $past(regAddr) == OFF_DIAG)
    else $error("diagStart without a write");
  diag_end_a: assert property (
    diagRunning && diagDone |=> clear_seq)
    else $error("enable bit did not clear after done");
  run_hold_a: assert property (
    diagRunning && !diagDone && !$past(diagDone) |=> diagRunning)
    else $error("test ended without done");
  adv_read_a: assert property (
    regRdStb && regAddr == OFF_ADVERT |=> {regRdData[15:10], regRdData[8:0]} ==
    {5'h00, $past(advertise[4]), $past(advertise[3:0]), 5'h01})
    else $error("advertisement read word wrong");
  lp_read_a: assert property (
    regRdStb && regAddr == OFF_PARTNER |=> {regRdData[15:11], regRdData[9], regRdData[4:0]} == 11'h001)
    else $error("partner fixed bits wrong");
endmodule // pacd_regs_chk

bind pacd_regs pacd_regs_chk pacd_regs_chk_inst (.sys_clk(sys_clk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .advertise(advertise), .partnerAbility(partnerAbility),
  .diagStart(diagStart), .diagRunning(diagRunning), .diagDone(diagDone),
  .diagOutcome(diagOutcome), .polarityReversed(polarityReversed),
  .crossoverState(crossoverState), .specialCtrl(specialCtrl));

/* testbench/test_pacd_regs.sv */
/*
  Self-checking bench for pacd_regs: reset values, register access, status and diagnostics.
  Assumes a 50 MHz sys_clk; the bench drives every port itself.
*/
module test_pacd_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import pacd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic diagDone = 1'b0;
  logic polarityReversed = 1'b0;
  logic crossoverState = 1'b0;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 16'h0000;
  logic [DATA_W-1:0] regRdData;
  pacd_ability_type advertise;
  pacd_ability_type partnerAbility = '0;
  logic diagStart;
  logic diagRunning;
  pacd_diag_type diagOutcome = '0;
  pacd_special_type specialCtrl;
  int badCount = 0;
  int samplesChecked = 0;

  pacd_regs pacd_regs_inst (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .advertise(advertise), .partnerAbility(partnerAbility), .diagStart(diagStart),
    .diagRunning(diagRunning), .diagDone(diagDone), .diagOutcome(diagOutcome),
    .polarityReversed(polarityReversed), .crossoverState(crossoverState),
    .specialCtrl(specialCtrl));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] mask);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1;
    check("regRdData", regRdData & mask, exp);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic test_reset;
    #1;
    check("advertise", 16'(advertise), 16'h001f);
    check("specialCtrl", 16'(specialCtrl), 16'h0002);
    rd(OFF_DIAG, 16'h0000, 16'hefff);
    rd(OFF_SPECIAL, 16'h0004, 16'hffff);
    rd(OFF_ADVERT, 16'h05e1, 16'hffff);
    rd(OFF_PARTNER, 16'h0001, 16'hffff);
    $display("test_reset done");
  endtask

  task automatic test_advert;
    for (int i = 5; i <= 10; i++) begin
      wr(OFF_ADVERT, 16'h0001 << i);
      rd(OFF_ADVERT, (16'h0001 << i) | 16'h0001, 16'hffff);
    end
    wr(OFF_ADVERT, 16'hffff);
    rd(OFF_ADVERT, 16'h07e1, 16'hffff);
    check("advertise", 16'(advertise), 16'h001f);
    wr(OFF_ADVERT, 16'h0520);
    #1;
    check("advertise", 16'(advertise), 16'h0019);
    wr(OFF_PARTNER, 16'hffff);
    rd(OFF_PARTNER, 16'h0001, 16'hffff);
    rd(4'h4, 16'h0000, 16'hffff);
    $display("test_advert done");
  endtask

  task automatic test_partner;
    @(posedge sys_clk);
    partnerAbility <= pacd_ability_type'(5'b10101);
    rd(OFF_PARTNER, 16'h04a1, 16'hffff);
    @(posedge sys_clk);
    partnerAbility <= pacd_ability_type'(5'b01010);
    rd(OFF_PARTNER, 16'h0141, 16'hffff);
    $display("test_partner done");
  endtask

  task automatic test_special;
    @(posedge sys_clk);
    polarityReversed <= 1'b1;
    wr(OFF_SPECIAL, 16'hffff);
    rd(OFF_SPECIAL, 16'h002f, 16'hffff);
    check("specialCtrl", 16'(specialCtrl), 16'h0007);
    @(posedge sys_clk);
    polarityReversed <= 1'b0;
    crossoverState <= 1'b1;
    wr(OFF_SPECIAL, 16'h0002);
    rd(OFF_SPECIAL, 16'h0012, 16'hffff);
    check("specialCtrl", 16'(specialCtrl), 16'h0001);
    $display("test_special done");
  endtask

  task automatic test_diag;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_DIAG, 16'h8000);
      #1;
      check("diagStart", 16'(diagStart), 16'h0001);
      rd(OFF_DIAG, 16'h8000, 16'h8000);
      check("diagStart", 16'(diagStart), 16'h0000);
      wr(OFF_DIAG, 16'h0000);
      check("diagRunning", 16'(diagRunning), 16'h0001);
      // A second start while running must not pulse the engine again
      wr(OFF_DIAG, 16'h8000);
      #1;
      check("diagStart", 16'(diagStart), 16'h0000);
      @(posedge sys_clk);
      diagDone <= 1'b1;
      diagOutcome <= pacd_diag_type'({2'(c), c[1], c[0] ? 9'h1ff : 9'h000});
      @(posedge sys_clk);
      diagDone <= 1'b0;
      for (n = 0; n < 8 && diagRunning !== 1'b0; n++) begin
        @(posedge sys_clk);
      end
      check("diagRunning", 16'(diagRunning), 16'h0000);
      if (n == 8) begin
        summarize();
      end
      rd(OFF_DIAG, {1'b0, 2'(c), c[1], 3'h0, c[0] ? 9'h1ff : 9'h000}, 16'hffff);
    end
    // A done pulse while idle must leave the results alone
    @(posedge sys_clk);
    diagDone <= 1'b1;
    diagOutcome <= pacd_diag_type'(12'h000);
    @(posedge sys_clk);
    diagDone <= 1'b0;
    rd(OFF_DIAG, 16'h71ff, 16'hffff);
    $display("test_diag done");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_advert();
    test_partner();
    test_special();
    test_diag();
    summarize();
  end
endmodule // test_pacd_regs
